// ===== src/rcl_pkg.sv
// constants, types and state layout for the reset source and cause logic
// Contract
// - generic brownout is main OR low-power request
// - one shared brownout flag for both detectors
// - low-power monitor gated, erased fuse disables it
// - pin reset enabled by lvp or pin cfg
// - enabled pin held low holds device reset
// - filter pin, short pulses detected and ignored
// - never drive reset pin low internally
// - disabled pin is input, software owns pull-up
// - watchdog timeout resets, updates timeout/powerdown flags
// - reset instruction resets, clears its flag
// - stack fault resets only when enabled, flagged
// - programming mode exit acts like power-on
// - run only after timer, oscillator, pin done
// - timers run regardless of pin level
// - power-up delay only after power/brownout, cfg_n
// - power-on sets timeout and powerdown flags
// - vector 0000h, power-on/brownout flag values
// - watchdog reset and watchdog wake flag updates
// - pin reset awake clears only pin flag
// - pin reset asleep: timeout set, powerdown clear
// - interrupt wake with enable goes to 0004h
// - stack over/under resets set their flags
// - unimplemented bits read zero
// - power-up timer holds reset 64 ms
package rcl_pkg;

	// clock and timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_MHZ = 25;
	localparam int POWERUP_TIME_US = 64000;
	localparam int POWERUP_CYCLES = POWERUP_TIME_US * CLK_MHZ;
	localparam int PIN_FILTER_NS = 320;
	localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_RESET_CYCLES = 4;
	localparam int SETTLE_CYCLES = 3;
	localparam int CNT_W = 21;
	localparam int FILT_W = 4;

	// register byte addresses
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CAUSE = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_STATE = 8'h0C;

	// field positions
	localparam int STAT_TO_BIT = 4;
	localparam int STAT_PD_BIT = 3;
	localparam int CB_STK_OVF = 7;
	localparam int CB_STK_UNF = 6;
	localparam int CB_WDT = 4;
	localparam int CB_PIN = 3;
	localparam int CB_RI = 2;
	localparam int CB_POR = 1;
	localparam int CB_BOR = 0;
	localparam int CTRL_PULLUP_BIT = 0;
	localparam int ST_RST_BIT = 0;
	localparam int ST_NOISE_BIT = 1;
	localparam int ST_FSM_LSB = 4;

	// flag values
	localparam logic [7:0] CAUSE_IMPL_MASK = 8'hDF;
	localparam logic [7:0] CAUSE_POR_VAL = 8'h1C;
	localparam logic [7:0] CAUSE_BOR_KEEP = 8'h02;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] INT_VECTOR = 16'h0004;

	// synchroniser bit indices
	localparam int SY_PIN = 0;
	localparam int SY_MBO = 1;
	localparam int SY_LBO = 2;
	localparam int SY_PROG = 3;
	localparam int SY_OST = 4;
	localparam int SY_CFG = 5;
	localparam int SY_W = 11;
	localparam logic [SY_W-1:0] SYNC_RST_VAL = 11'h001;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} rcl_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} rcl_apb_rsp_t;

	typedef struct packed {
		logic ost_required;
		logic powerup_timer_cfg_n;
		logic stack_fault_reset_en;
		logic low_voltage_prog_cfg;
		logic pin_reset_cfg_en;
		logic lp_monitor_cfg_n;
	} rcl_cfg_t;

	typedef struct packed {
		logic watchdog_timeout;
		logic reset_instr;
		logic stack_over;
		logic stack_under;
		logic sleeping;
		logic wake_int;
		logic global_int_enable;
	} rcl_core_ev_t;

	typedef struct packed {
		logic device_reset;
		logic pc_load;
		logic [15:0] pc_addr;
		logic wake_resume;
		logic int_vector_req;
	} rcl_core_ctl_t;

	typedef struct packed {
		logic out;
		logic oe;
		logic pullup_en;
		logic gpio_value;
	} rcl_pin_t;

	typedef enum logic [2:0] {S_HOLD, S_TIMERS, S_PIN, S_RUN, S_PULSE} rcl_fsm_t;

	typedef struct packed {
		logic [SY_W-1:0] sync1;
		logic [SY_W-1:0] sync2;
		rcl_fsm_t fsm;
		logic [CNT_W-1:0] cnt;
		logic [FILT_W-1:0] filt_cnt;
		logic pin_low;
		logic noise_seen;
		logic bo_prev;
		logic prog_prev;
		logic timeout_flag;
		logic powerdown_flag;
		logic [7:0] cause;
		logic pullup_sw;
		rcl_apb_rsp_t apb;
		rcl_core_ctl_t core;
		rcl_pin_t pin;
	} rcl_state_t;

endpackage

// ===== src/rcl_reset_cause.sv
// reset source merging, start-up sequencing and reset cause flags with apb access
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module rcl_reset_cause #(
	parameter int unsigned POWERUP_CYCLES = rcl_pkg::POWERUP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire rcl_pkg::rcl_apb_req_t apb_req,
	output rcl_pkg::rcl_apb_rsp_t apb_rsp,
	input wire logic master_clear_pin,
	input wire logic main_brownout_rst,
	input wire logic low_power_brownout,
	input wire logic prog_mode,
	input wire logic ost_done,
	input wire rcl_pkg::rcl_cfg_t cfg_in,
	input wire rcl_pkg::rcl_core_ev_t core_ev,
	output rcl_pkg::rcl_core_ctl_t core_ctl,
	output rcl_pkg::rcl_pin_t pin_ctl
);
	import rcl_pkg::*;

	rcl_state_t s;
	rcl_state_t next_s;
	rcl_cfg_t cfg;
	logic brownout;
	logic prog;
	logic pin_en;
	logic pin_hold;
	logic raw_low;
	logic hit;
	logic wr;
	logic [31:0] rd_data;
	logic [7:0] sw_cause;
	logic [7:0] ev_keep;
	logic [7:0] ev_val;
	logic [1:0] st_keep;
	logic [1:0] st_val;
	logic sw_noise_clr;
	logic noise_set;

	// state reset values: power-on flag pattern, device held in reset
	localparam rcl_state_t RESET_STATE = '{
		sync1: SYNC_RST_VAL,
		sync2: SYNC_RST_VAL,
		fsm: S_HOLD,
		cnt: CNT_W'(SETTLE_CYCLES),
		filt_cnt: '0,
		pin_low: 1'b0,
		noise_seen: 1'b0,
		bo_prev: 1'b0,
		prog_prev: 1'b0,
		timeout_flag: 1'b1,
		powerdown_flag: 1'b1,
		cause: CAUSE_POR_VAL,
		pullup_sw: 1'b0,
		apb: '0,
		core: '{device_reset: 1'b1, pc_load: 1'b0, pc_addr: RESET_VECTOR,
			wake_resume: 1'b0, int_vector_req: 1'b0},
		pin: '0
	};

	// register read mux and address decode
	always_comb begin
		rd_data = '0;
		hit = 1'b1;
		if (apb_req.paddr == ADDR_STATUS) begin
			rd_data[STAT_TO_BIT] = s.timeout_flag;
			rd_data[STAT_PD_BIT] = s.powerdown_flag;
		end else if (apb_req.paddr == ADDR_CAUSE) begin
			rd_data[7:0] = s.cause & CAUSE_IMPL_MASK;
		end else if (apb_req.paddr == ADDR_CTRL) begin
			rd_data[CTRL_PULLUP_BIT] = s.pullup_sw;
		end else if (apb_req.paddr == ADDR_STATE) begin
			rd_data[ST_RST_BIT] = s.core.device_reset;
			rd_data[ST_NOISE_BIT] = s.noise_seen;
			rd_data[ST_FSM_LSB +: 3] = s.fsm;
		end else begin
			hit = 1'b0;
		end
	end

	// next state
	always_comb begin
		next_s = s;
		// two-flop synchronisers for pin, detectors and fuses
		next_s.sync1 = {cfg_in, ost_done, prog_mode, low_power_brownout,
			main_brownout_rst, master_clear_pin};
		next_s.sync2 = s.sync1;
		cfg = rcl_cfg_t'(s.sync2[SY_W-1:SY_CFG]);

		brownout = s.sync2[SY_MBO] | (s.sync2[SY_LBO] & ~cfg.lp_monitor_cfg_n);
		prog = s.sync2[SY_PROG];
		pin_en = cfg.low_voltage_prog_cfg | cfg.pin_reset_cfg_en;
		raw_low = ~s.sync2[SY_PIN];
		pin_hold = pin_en & s.pin_low;
		next_s.bo_prev = brownout;
		next_s.prog_prev = prog;

		// pin glitch filter: level must stand for the full filter length
		sw_noise_clr = 1'b0;
		noise_set = 1'b0;
		if (raw_low != s.pin_low) begin
			if (s.filt_cnt == FILT_W'(PIN_FILTER_CYCLES - 1)) begin
				next_s.pin_low = raw_low;
				next_s.filt_cnt = '0;
			end else begin
				next_s.filt_cnt = s.filt_cnt + FILT_W'(1);
			end
		end else if (s.filt_cnt != '0) begin
			next_s.filt_cnt = '0;
			next_s.noise_seen = 1'b1;
			noise_set = 1'b1;
		end

		// apb slave: ready one cycle after setup, write at access edge
		wr = apb_req.psel & apb_req.penable & s.apb.pready & apb_req.pwrite;
		next_s.apb = '0;
		if (apb_req.psel && !apb_req.penable) begin
			next_s.apb.pready = 1'b1;
			next_s.apb.pslverr = ~hit;
			next_s.apb.prdata = apb_req.pwrite ? '0 : rd_data;
		end
		sw_cause = s.cause;
		if (wr && apb_req.paddr == ADDR_CAUSE) begin
			sw_cause = apb_req.pwdata[7:0] & CAUSE_IMPL_MASK;
		end
		if (wr && apb_req.paddr == ADDR_CTRL) begin
			next_s.pullup_sw = apb_req.pwdata[CTRL_PULLUP_BIT];
		end
		if (wr && apb_req.paddr == ADDR_STATE && apb_req.pwdata[ST_NOISE_BIT]) begin
			sw_noise_clr = 1'b1;
		end
		// a glitch seen in the same cycle as the clear keeps the flag set
		if (sw_noise_clr && !noise_set) begin
			next_s.noise_seen = 1'b0;
		end

		// hardware flag events: keep mask and value, applied after software
		ev_keep = 8'hFF;
		ev_val = 8'h00;
		st_keep = 2'b11;
		st_val = 2'b00;
		next_s.core.pc_load = 1'b0;
		next_s.core.wake_resume = 1'b0;
		next_s.core.int_vector_req = 1'b0;

		if (brownout) begin
			if (!s.bo_prev) begin
				ev_keep = CAUSE_BOR_KEEP;
				ev_val = CAUSE_POR_VAL & ~CAUSE_BOR_KEEP;
				st_keep = 2'b00;
				st_val = 2'b11;
			end
			next_s.fsm = S_HOLD;
			next_s.cnt = '0;
		end else if (prog) begin
			next_s.fsm = S_HOLD;
			next_s.cnt = '0;
		end else if (s.prog_prev) begin
			ev_keep = 8'h00;
			ev_val = CAUSE_POR_VAL;
			st_keep = 2'b00;
			st_val = 2'b11;
			next_s.fsm = S_HOLD;
			next_s.cnt = '0;
		end else begin
			case (s.fsm)
				S_HOLD: begin
					if (s.cnt != '0) begin
						next_s.cnt = s.cnt - CNT_W'(1);
					end else begin
						next_s.fsm = S_TIMERS;
						next_s.cnt = cfg.powerup_timer_cfg_n ? '0 :
							CNT_W'(POWERUP_CYCLES - 1);
					end
				end
				S_TIMERS: begin
					// timers ignore the pin level
					if (s.cnt != '0) begin
						next_s.cnt = s.cnt - CNT_W'(1);
					end else if (!cfg.ost_required || s.sync2[SY_OST]) begin
						next_s.fsm = S_PIN;
					end
				end
				S_PIN: begin
					if (!pin_hold) begin
						next_s.fsm = S_RUN;
						next_s.core.pc_load = 1'b1;
						next_s.core.pc_addr = RESET_VECTOR;
					end
				end
				S_RUN: begin
					if (pin_hold) begin
						ev_keep = ~(8'h01 << CB_PIN);
						if (core_ev.sleeping) begin
							st_keep = 2'b00;
							st_val = 2'b10;
						end
						next_s.fsm = S_PIN;
					end else if (core_ev.watchdog_timeout) begin
						if (core_ev.sleeping) begin
							st_keep = 2'b00;
							next_s.core.wake_resume = 1'b1;
						end else begin
							st_keep = 2'b01;
							ev_keep = ~(8'h01 << CB_WDT);
							next_s.fsm = S_PULSE;
							next_s.cnt = CNT_W'(INT_RESET_CYCLES - 1);
						end
					end else if (core_ev.wake_int && core_ev.sleeping) begin
						st_keep = 2'b00;
						st_val = 2'b10;
						next_s.core.wake_resume = 1'b1;
						next_s.core.int_vector_req = core_ev.global_int_enable;
						next_s.core.pc_addr = INT_VECTOR;
					end else if (core_ev.reset_instr) begin
						ev_keep = ~(8'h01 << CB_RI);
						next_s.fsm = S_PULSE;
						next_s.cnt = CNT_W'(INT_RESET_CYCLES - 1);
					end else if (core_ev.stack_over && cfg.stack_fault_reset_en) begin
						ev_keep = ~(8'h01 << CB_STK_OVF);
						ev_val = 8'h01 << CB_STK_OVF;
						next_s.fsm = S_PULSE;
						next_s.cnt = CNT_W'(INT_RESET_CYCLES - 1);
					end else if (core_ev.stack_under && cfg.stack_fault_reset_en) begin
						ev_keep = ~(8'h01 << CB_STK_UNF);
						ev_val = 8'h01 << CB_STK_UNF;
						next_s.fsm = S_PULSE;
						next_s.cnt = CNT_W'(INT_RESET_CYCLES - 1);
					end
				end
				S_PULSE: begin
					if (s.cnt != '0) begin
						next_s.cnt = s.cnt - CNT_W'(1);
					end else begin
						next_s.fsm = S_PIN;
					end
				end
				default: begin
					next_s.fsm = S_HOLD;
				end
			endcase
		end

		// hardware event wins over a same-cycle software write
		next_s.cause = ((sw_cause & ev_keep) | (ev_val & ~ev_keep)) & CAUSE_IMPL_MASK;
		next_s.timeout_flag = st_keep[1] ? s.timeout_flag : st_val[1];
		next_s.powerdown_flag = st_keep[0] ? s.powerdown_flag : st_val[0];

		// reset output leaves only through the clocked sequencer
		next_s.core.device_reset = (next_s.fsm != S_RUN);

		// pin side: never driven, pull-up forced while pin resets
		next_s.pin.out = 1'b0;
		next_s.pin.oe = 1'b0;
		next_s.pin.pullup_en = pin_en ? 1'b1 : s.pullup_sw;
		next_s.pin.gpio_value = s.sync2[SY_PIN];
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= RESET_STATE;
		end else begin
			s <= next_s;
		end
	end

	// outputs straight from flops
	assign apb_rsp = s.apb;
	assign core_ctl = s.core;
	assign pin_ctl = s.pin;

endmodule

// ===== bench/rcl_props.sv
// assertions on the ports of the reset source and cause block
`timescale 1ns/100ps
module rcl_props #(
	parameter int unsigned POWERUP_CYCLES = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire rcl_pkg::rcl_apb_req_t apb_req,
	input wire rcl_pkg::rcl_apb_rsp_t apb_rsp,
	input wire logic master_clear_pin,
	input wire logic main_brownout_rst,
	input wire logic low_power_brownout,
	input wire logic prog_mode,
	input wire logic ost_done,
	input wire rcl_pkg::rcl_cfg_t cfg_in,
	input wire rcl_pkg::rcl_core_ev_t core_ev,
	input wire rcl_pkg::rcl_core_ctl_t core_ctl,
	input wire rcl_pkg::rcl_pin_t pin_ctl
);
	import rcl_pkg::*;
	logic [7:0] low_n;
	logic [31:0] hold_n;
	logic first;
	wire pin_en = cfg_in.low_voltage_prog_cfg | cfg_in.pin_reset_cfg_en;
	// pin-low run length, reset length, first start-up after power-on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_n <= 8'h00;
			hold_n <= 32'h0;
			first <= 1'b1;
		end else begin
			low_n <= (pin_en && !master_clear_pin) ? low_n + {7'h00, low_n != 8'hFF} : 8'h00;
			hold_n <= core_ctl.device_reset ? hold_n + 32'h1 : 32'h0;
			if (core_ctl.pc_load) begin
				first <= 1'b0;
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_no_drive; !pin_ctl.oe && !pin_ctl.out; endproperty
	a_no_drive: assert property (p_no_drive) else $error("pin driven");
	property p_bo_main; main_brownout_rst [*3] |-> ##[1:2] core_ctl.device_reset; endproperty
	a_bo_main: assert property (p_bo_main) else $error("no brownout reset");
	property p_bo_lp;
		(low_power_brownout && !cfg_in.lp_monitor_cfg_n) [*3] |-> ##[1:2] core_ctl.device_reset;
	endproperty
	a_bo_lp: assert property (p_bo_lp) else $error("no low power reset");
	property p_pin_hold; low_n >= 8'h0E |-> core_ctl.device_reset; endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("pin low not held");
	property p_vec;
		core_ctl.pc_load |-> !core_ctl.device_reset && $past(core_ctl.device_reset)
			&& core_ctl.pc_addr == RESET_VECTOR;
	endproperty
	a_vec: assert property (p_vec) else $error("bad release vector");
	property p_wdt;
		core_ev.watchdog_timeout && !core_ev.sleeping && !core_ctl.device_reset
			|=> core_ctl.device_reset [*5];
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog reset short");
	property p_stk_off;
		core_ev.stack_over && !cfg_in.stack_fault_reset_en && master_clear_pin
			&& !core_ctl.device_reset && !core_ev.watchdog_timeout |=> !core_ctl.device_reset;
	endproperty
	a_stk_off: assert property (p_stk_off) else $error("stack reset when off");
	property p_wake;
		core_ev.wake_int && core_ev.sleeping && core_ev.global_int_enable && master_clear_pin
			&& !core_ev.watchdog_timeout && !core_ctl.device_reset
			|=> core_ctl.int_vector_req && core_ctl.wake_resume && core_ctl.pc_addr == INT_VECTOR;
	endproperty
	a_wake: assert property (p_wake) else $error("bad interrupt wake");
	property p_apb; apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready;
	endproperty
	a_apb: assert property (p_apb) else $error("bad bus answer");
	property p_powerup_timer;
		core_ctl.pc_load && first && !cfg_in.powerup_timer_cfg_n |-> hold_n >= POWERUP_CYCLES;
	endproperty
	a_powerup_timer: assert property (p_powerup_timer) else $error("power-up timer short");
	c_wake: cover property (core_ctl.int_vector_req);
	c_err: cover property (apb_rsp.pslverr);
	c_start: cover property (core_ctl.pc_load && first);
endmodule
bind rcl_reset_cause rcl_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) props_u (
	.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.master_clear_pin(master_clear_pin), .main_brownout_rst(main_brownout_rst),
	.low_power_brownout(low_power_brownout), .prog_mode(prog_mode), .ost_done(ost_done),
	.cfg_in(cfg_in), .core_ev(core_ev), .core_ctl(core_ctl), .pin_ctl(pin_ctl)
);

// ===== bench/rcl_pin_model.sv
// external reset button on the pin with the weak pull-up
`timescale 1ns/100ps
module rcl_pin_model (
	input wire logic pclk,
	input wire logic press,
	input wire logic oe,
	input wire logic out,
	output logic pin
);
	logic held = 1'b0;
	// button changes only after a clock edge
	always @(posedge pclk) begin
		held <= press;
	end
	// device drive wins, else button, else pull-up high
	assign pin = oe ? out : !held;
endmodule

// ===== bench/tb_rcl_reset_cause.sv
// self-checking bench for the reset source and cause block
`timescale 1ns/100ps
module tb_rcl_reset_cause;
	import rcl_pkg::*;
	logic pclk = 1'b0;
	logic presetn;
	logic press = 1'b1;
	logic mbo = 1'b0;
	logic lbo = 1'b0;
	logic prog = 1'b0;
	logic ost = 1'b0;
	rcl_apb_req_t req = '0;
	rcl_apb_rsp_t rsp;
	rcl_cfg_t cfg = 6'h23;
	rcl_core_ev_t ev = '0;
	rcl_core_ctl_t ctl;
	rcl_pin_t pc;
	logic pin;
	logic [31:0] rdat;
	logic rerr;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;
	rcl_reset_cause #(.POWERUP_CYCLES(20)) dut_u (
		.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.master_clear_pin(pin), .main_brownout_rst(mbo), .low_power_brownout(lbo),
		.prog_mode(prog), .ost_done(ost), .cfg_in(cfg), .core_ev(ev),
		.core_ctl(ctl), .pin_ctl(pc)
	);
	rcl_pin_model pin_u (.pclk(pclk), .press(press), .oe(pc.oe), .out(pc.out), .pin(pin));
	// clock and hang guard
	always #20 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one bus transfer, held until pready is sampled
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, exp);
	endtask
	task automatic run_wait();
		do @(posedge pclk); while (ctl.device_reset !== 1'b0);
	endtask
	// core event pulse, then flags once running again
	task automatic t_ev(input rcl_core_ev_t e, input logic [7:0] c, input logic [7:0] s);
		logic [1:0] wk;
		wk = {e.sleeping & (e.wake_int | e.watchdog_timeout),
			e.sleeping & e.wake_int & e.global_int_enable};
		@(posedge pclk);
		ev <= e;
		@(posedge pclk);
		ev <= e & 7'h05;
		// wake pulses stand for the one cycle after the event
		@(posedge pclk);
		chk({ctl.wake_resume, ctl.int_vector_req}, wk);
		if (e.wake_int) begin
			chk(ctl.pc_addr, INT_VECTOR);
		end
		tick(2);
		run_wait();
		rd(ADDR_CAUSE, {24'h0, c});
		rd(ADDR_STATUS, {24'h0, s});
		ev <= '0;
	endtask
	// long pin press awake or asleep
	task automatic t_pin(input logic slp, input logic [7:0] s);
		apb(1'b1, ADDR_CAUSE, 32'hCB);
		ev.sleeping <= slp;
		press <= 1'b1;
		tick(20);
		press <= 1'b0;
		run_wait();
		chk({ctl.pc_load, ctl.pc_addr}, {1'b1, RESET_VECTOR});
		rd(ADDR_CAUSE, 32'hC3);
		rd(ADDR_STATUS, {24'h0, s});
		ev <= '0;
	endtask
	// power-on start-up with late oscillator and pin held
	task automatic t_por();
		tick(40);
		chk(ctl.device_reset, 1);
		ost <= 1'b1;
		tick(10);
		chk(ctl.device_reset, 1);
		press <= 1'b0;
		tick(16);
		chk(ctl.device_reset, 0);
		chk({pc.oe, pc.out}, 0);
		rd(ADDR_STATUS, 32'h18);
		rd(ADDR_CAUSE, 32'h1C);
		apb(1'b1, ADDR_CAUSE, 32'hFF);
		rd(ADDR_CAUSE, 32'hDF);
		apb(1'b0, 8'h10, 32'h0);
		chk(rerr, 1);
		chk(rdat, 0);
		apb(1'b1, ADDR_CAUSE, 32'h1F);
	endtask
	initial begin
		presetn = 1'b0;
		tick(20);
		presetn <= 1'b1;
		t_por();
		t_ev(7'h10, 8'h1F, 8'h18);
		cfg.stack_fault_reset_en <= 1'b1;
		tick(6);
		t_ev(7'h10, 8'h9F, 8'h18);
		t_ev(7'h08, 8'hDF, 8'h18);
		t_ev(7'h40, 8'hCF, 8'h08);
		t_ev(7'h20, 8'hCB, 8'h08);
		t_pin(1'b0, 8'h08);
		t_ev(7'h07, 8'hC3, 8'h10);
		t_ev(7'h44, 8'hC3, 8'h00);
		t_pin(1'b1, 8'h10);
		press <= 1'b1;
		tick(3);
		press <= 1'b0;
		tick(14);
		chk(ctl.device_reset, 0);
		rd(ADDR_STATE, 32'h32);
		apb(1'b1, ADDR_STATE, 32'h2);
		rd(ADDR_STATE, 32'h30);
		for (int i = 0; i < 4; i++) begin
			cfg.low_voltage_prog_cfg <= i[1];
			cfg.pin_reset_cfg_en <= i[0];
			tick(6);
			chk(pc.pullup_en, i != 0);
		end
		cfg.low_voltage_prog_cfg <= 1'b0;
		cfg.pin_reset_cfg_en <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h1);
		press <= 1'b1;
		tick(20);
		chk(ctl.device_reset, 0);
		chk(pc.pullup_en, 1);
		chk(pc.gpio_value, 0);
		press <= 1'b0;
		lbo <= 1'b1;
		tick(16);
		chk(ctl.device_reset, 0);
		cfg.pin_reset_cfg_en <= 1'b1;
		cfg.lp_monitor_cfg_n <= 1'b0;
		lbo <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, ADDR_CAUSE, 32'hFF);
			{prog, mbo, lbo} <= 3'h1 << i;
			tick(6);
			{prog, mbo, lbo} <= 3'h0;
			tick(3);
			run_wait();
			rd(ADDR_CAUSE, i == 2 ? 32'h1C : 32'h1E);
			rd(ADDR_STATUS, 32'h18);
		end
		// brownout with the power-up timer and oscillator wait both off
		cfg.powerup_timer_cfg_n <= 1'b1;
		cfg.ost_required <= 1'b0;
		tick(3);
		mbo <= 1'b1;
		tick(6);
		chk(ctl.device_reset, 1);
		mbo <= 1'b0;
		tick(8);
		chk(ctl.device_reset, 0);
		tally_and_finish();
	end
endmodule
